/* sps_map.svh */
// Register offsets, field positions, reset values and counts of the pin mux
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// Shared lines, as indices into the per-line vectors
`define SPS_NUM_LINES 5
`define SPS_LN_TDI 0
`define SPS_LN_TDO 1
`define SPS_LN_TMS 2
`define SPS_LN_TCK 3
`define SPS_LN_ERASE 4

// Bit positions in the system I/O select word (1 = general I/O)
`define SPS_SELB_TDI 4
`define SPS_SELB_TDO 5
`define SPS_SELB_TMS 6
`define SPS_SELB_TCK 7
`define SPS_SELB_ERASE 12

// Register byte offsets
`define SPS_OFF_SYSIO 8'h00
`define SPS_OFF_STATUS 8'h04
`define SPS_OFF_PADCFG 8'h10

// Status word fields
`define SPS_ST_SWD 0
`define SPS_ST_BSCAN 1
`define SPS_ST_ERASE 2
`define SPS_ST_PIN_LO 4

// Reset values
`define SPS_SYSIO_RESET 5'h0
`define SPS_PADCFG_RESET 8'h00

// Debug protocol switch sequence
`define SPS_LINE_RESET_BITS 50
`define SPS_SEQ_LEN 16
`define SPS_SEQ_TO_SWD 16'hE79E
`define SPS_SEQ_TO_JTAG 16'hE73C

`endif

/* sps_pkg.sv */
// Types shared by the system I/O pin select block
package sps_pkg;

    typedef logic [7:0] sps_addr_t;
    typedef logic [31:0] sps_data_t;

    // Pad settings of one line; all but periph_own apply in every mode
    typedef struct packed {
        logic periph_own;
        logic change_irq;
        logic debounce;
        logic glitch;
        logic open_drain;
        logic schmitt;
        logic pull_down;
        logic pull_up;
    } sps_pad_cfg_s;

    // Switch sequence detector
    typedef enum logic [1:0] {
        SPS_HUNT,
        SPS_COLLECT,
        SPS_TRAIL
    } sps_seq_e;

endpackage

/* sps_system_io_pin_select.sv */
// System I/O pin select: debug, erase and general I/O sharing of five pads
`timescale 1ns/1ps
`include "sps_map.svh"

module sps_system_io_pin_select #(
    parameter int N_LINES = `SPS_NUM_LINES,
    parameter int LINE_RESET_BITS = `SPS_LINE_RESET_BITS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire sps_pkg::sps_addr_t reg_addr,
    input wire sps_pkg::sps_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output sps_pkg::sps_data_t reg_rdata,
    input wire logic [N_LINES-1:0] pad_in,
    output logic [N_LINES-1:0] pad_out,
    output logic [N_LINES-1:0] pad_oe_n,
    output sps_pkg::sps_pad_cfg_s [N_LINES-1:0] pad_cfg,
    input wire logic boundary_scan_select_pin,
    output logic bscan_mode,
    output logic dbg_tck,
    output logic dbg_tms,
    output logic dbg_tdi,
    input wire logic scan_tdo_data,
    input wire logic scan_tdo_en,
    input wire logic swdio_out,
    input wire logic swdio_drive,
    input wire logic async_trace_output,
    output logic swd_active,
    output logic erase_request,
    input wire logic [N_LINES-1:0] port_ctl_out,
    input wire logic [N_LINES-1:0] port_ctl_drive,
    output logic [N_LINES-1:0] port_ctl_in,
    input wire logic [N_LINES-1:0] periph_out,
    input wire logic [N_LINES-1:0] periph_drive,
    output logic [N_LINES-1:0] periph_in
);
    import sps_pkg::*;

    localparam int CW = $clog2(LINE_RESET_BITS + 1);

    // The line mapping below is fixed to five pads
    if (N_LINES != `SPS_NUM_LINES || LINE_RESET_BITS < 2) begin : g_bad
        $error("sps: unsupported parameter values");
    end

    logic rst_meta;
    logic rst_n_sync;
    logic [N_LINES-1:0] pad_meta;
    logic [N_LINES-1:0] pad_sync;
    logic bsel_meta;
    logic bsel_sync;
    logic tck_prev;
    logic tck_rise;
    logic [N_LINES-1:0] sel_reg;
    logic [N_LINES-1:0] sys_mode;
    sps_pad_cfg_s [N_LINES-1:0] cfg_reg;
    logic [7:0] cfg_off;
    logic cfg_hit;
    logic [2:0] cfg_idx;
    sps_data_t rdata_reg;
    sps_data_t rdata_next;
    logic swd_reg;
    sps_seq_e seq_reg;
    logic [CW-1:0] ones_reg;
    logic [`SPS_SEQ_LEN-1:0] shift_reg;
    logic [3:0] bitcnt_reg;
    logic [`SPS_SEQ_LEN-1:0] word_in;
    logic line_reset;
    logic seq_live;
    logic tms_bit;
    logic [N_LINES-1:0] sys_out;
    logic [N_LINES-1:0] sys_drive;

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_sync <= rst_meta;
        end
    end

    // Pad inputs are asynchronous to core_clk
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pad_meta <= '0;
            pad_sync <= '0;
            bsel_meta <= 1'b0;
            bsel_sync <= 1'b0;
            tck_prev <= 1'b0;
        end else begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
            bsel_meta <= boundary_scan_select_pin;
            bsel_sync <= bsel_meta;
            tck_prev <= pad_sync[`SPS_LN_TCK];
        end
    end

    assign tck_rise = pad_sync[`SPS_LN_TCK] && !tck_prev;
    assign tms_bit = pad_sync[`SPS_LN_TMS];
    // Low pin (pulled down when open) keeps normal debug operation
    assign bscan_mode = bsel_sync;

    // Select word: zero means system function, so reset favours it
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            sel_reg <= `SPS_SYSIO_RESET;
        end else if (reg_wr && reg_addr == `SPS_OFF_SYSIO) begin
            sel_reg[`SPS_LN_ERASE] <= reg_wdata[`SPS_SELB_ERASE];
            sel_reg[`SPS_LN_TCK] <= reg_wdata[`SPS_SELB_TCK];
            sel_reg[`SPS_LN_TMS] <= reg_wdata[`SPS_SELB_TMS];
            sel_reg[`SPS_LN_TDO] <= reg_wdata[`SPS_SELB_TDO];
            sel_reg[`SPS_LN_TDI] <= reg_wdata[`SPS_SELB_TDI];
        end
    end

    assign sys_mode = ~sel_reg;

    // Pad configuration window decode, one aligned word per line
    assign cfg_off = reg_addr - `SPS_OFF_PADCFG;
    assign cfg_idx = cfg_off[4:2];
    assign cfg_hit = reg_addr >= `SPS_OFF_PADCFG && cfg_off[1:0] == 2'h0
        && cfg_off[7:2] < 6'(N_LINES);

    // Each line keeps its own settings word
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            for (int i = 0; i < N_LINES; i++) begin
                cfg_reg[i] <= `SPS_PADCFG_RESET;
            end
        end else if (reg_wr && cfg_hit) begin
            cfg_reg[cfg_idx] <= reg_wdata[7:0];
        end
    end

    // Pad settings bypass the mode mux so they hold in debug use too
    assign pad_cfg = cfg_reg;

    // Read data in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_next = '0;
        if (reg_addr == `SPS_OFF_SYSIO) begin
            rdata_next[`SPS_SELB_ERASE] = sel_reg[`SPS_LN_ERASE];
            rdata_next[`SPS_SELB_TCK] = sel_reg[`SPS_LN_TCK];
            rdata_next[`SPS_SELB_TMS] = sel_reg[`SPS_LN_TMS];
            rdata_next[`SPS_SELB_TDO] = sel_reg[`SPS_LN_TDO];
            rdata_next[`SPS_SELB_TDI] = sel_reg[`SPS_LN_TDI];
        end else if (reg_addr == `SPS_OFF_STATUS) begin
            rdata_next[`SPS_ST_SWD] = swd_reg;
            rdata_next[`SPS_ST_BSCAN] = bsel_sync;
            rdata_next[`SPS_ST_ERASE] = erase_request;
            rdata_next[`SPS_ST_PIN_LO +: N_LINES] = pad_sync;
        end else if (cfg_hit) begin
            rdata_next[7:0] = cfg_reg[cfg_idx];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata = rdata_reg;

    // Detector listens only while the probe pins belong to the debug port
    assign seq_live = sys_mode[`SPS_LN_TCK] && sys_mode[`SPS_LN_TMS]
        && !bsel_sync;
    assign line_reset = ones_reg == CW'(LINE_RESET_BITS);
    assign word_in = {tms_bit, shift_reg[`SPS_SEQ_LEN-1:1]};

    // Run of consecutive high mode bits, cleared while a word is taken in
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ones_reg <= '0;
        end else if (!seq_live || seq_reg == SPS_COLLECT) begin
            ones_reg <= '0;
        end else if (tck_rise) begin
            if (!tms_bit) begin
                ones_reg <= '0;
            end else if (!line_reset) begin
                ones_reg <= ones_reg + CW'(1);
            end
        end
    end

    // Line reset, 16-bit word sent first bit first, then another reset
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            seq_reg <= SPS_HUNT;
            shift_reg <= '0;
            bitcnt_reg <= 4'h0;
        end else if (!seq_live) begin
            seq_reg <= SPS_HUNT;
        end else if (tck_rise) begin
            unique case (seq_reg)
                SPS_HUNT: begin
                    if (!tms_bit && line_reset) begin
                        seq_reg <= SPS_COLLECT;
                        shift_reg <= word_in;
                        bitcnt_reg <= 4'h1;
                    end
                end
                SPS_COLLECT: begin
                    shift_reg <= word_in;
                    bitcnt_reg <= bitcnt_reg + 4'h1;
                    if (bitcnt_reg == 4'hF) begin
                        if (word_in == (swd_reg ? `SPS_SEQ_TO_JTAG
                                                : `SPS_SEQ_TO_SWD)) begin
                            seq_reg <= SPS_TRAIL;
                        end else begin
                            seq_reg <= SPS_HUNT;
                        end
                    end
                end
                SPS_TRAIL: begin
                    if (!tms_bit || ones_reg == CW'(LINE_RESET_BITS - 1)) begin
                        seq_reg <= SPS_HUNT;
                    end
                end
            endcase
        end
    end

    // Protocol flag: scan chain after reset, flips on a whole sequence
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            swd_reg <= 1'b0;
        end else if (seq_live && tck_rise && seq_reg == SPS_TRAIL && tms_bit
                     && ones_reg == CW'(LINE_RESET_BITS - 1)) begin
            swd_reg <= !swd_reg;
        end
    end

    assign swd_active = swd_reg;

    // Debug inputs read zero when their pin has gone to general I/O
    assign dbg_tck = sys_mode[`SPS_LN_TCK] && pad_sync[`SPS_LN_TCK];
    assign dbg_tms = sys_mode[`SPS_LN_TMS] && pad_sync[`SPS_LN_TMS];
    assign dbg_tdi = sys_mode[`SPS_LN_TDI] && pad_sync[`SPS_LN_TDI];
    assign erase_request = sys_mode[`SPS_LN_ERASE]
        && pad_sync[`SPS_LN_ERASE];

    // System-side drive; clock, data-in and erase pins are inputs only
    always_comb begin
        sys_out = '0;
        sys_drive = '0;
        if (swd_reg) begin
            sys_out[`SPS_LN_TMS] = swdio_out;
            sys_drive[`SPS_LN_TMS] = swdio_drive;
            sys_out[`SPS_LN_TDO] = async_trace_output;
            sys_drive[`SPS_LN_TDO] = 1'b1;
        end else begin
            // Trace never reaches the pin here; the scan data owns it
            sys_out[`SPS_LN_TDO] = scan_tdo_data;
            sys_drive[`SPS_LN_TDO] = scan_tdo_en;
        end
    end

    // Per-line owner: system function, else port controller or peripheral
    for (genvar i = 0; i < N_LINES; i++) begin : g_line
        logic gpio_drive;
        logic gpio_out;
        assign gpio_drive = cfg_reg[i].periph_own ? periph_drive[i]
                                                  : port_ctl_drive[i];
        assign gpio_out = cfg_reg[i].periph_own ? periph_out[i]
                                                : port_ctl_out[i];
        assign pad_out[i] = sys_mode[i] ? sys_out[i] : gpio_out;
        assign pad_oe_n[i] = sys_mode[i] ? !sys_drive[i] : !gpio_drive;
        assign port_ctl_in[i] = pad_sync[i];
        assign periph_in[i] = !sys_mode[i] && cfg_reg[i].periph_own
            && pad_sync[i];
    end

    // Checks

    chk_reset_sysfunc: assert property (@(posedge core_clk)
        $rose(rst_n_sync) |->
        (&sys_mode && !erase_request == !pad_sync[`SPS_LN_ERASE]))
        else $error("shared pins not in system function after reset");

    chk_jtag_default: assert property (@(posedge core_clk)
        $rose(rst_n_sync) |-> !swd_active)
        else $error("debug port did not start in scan-chain mode");

    chk_erase_select: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        reg_wr && reg_addr == `SPS_OFF_SYSIO |=>
        sys_mode[`SPS_LN_ERASE] == !$past(reg_wdata[`SPS_SELB_ERASE]))
        else $error("erase select write not applied next cycle");

    chk_erase_gated: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        !sys_mode[`SPS_LN_ERASE] |-> !erase_request)
        else $error("erase raised while pin is general I/O");

    chk_debug_gpio: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        !sys_mode[`SPS_LN_TCK] && !cfg_reg[`SPS_LN_TCK].periph_own |->
        !dbg_tck && pad_out[`SPS_LN_TCK] == port_ctl_out[`SPS_LN_TCK])
        else $error("test clock line not handed to general I/O");

    chk_bscan_pin: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        boundary_scan_select_pin [*3] |-> bscan_mode)
        else $error("boundary-scan select high but mode not entered");

    sequence s_last_trail_bit;
        seq_live && tck_rise && seq_reg == SPS_TRAIL && tms_bit
        && ones_reg == CW'(LINE_RESET_BITS - 1);
    endsequence

    sequence s_flipped;
        swd_active != $past(swd_active) ##1 seq_reg == SPS_HUNT;
    endsequence

    chk_seq_switch: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        s_last_trail_bit |=> s_flipped)
        else $error("switch sequence did not change debug protocol");

    chk_seq_only: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        !$past(seq_reg == SPS_TRAIL) |-> $stable(swd_active))
        else $error("protocol changed without a full sequence");

    chk_trace_scan: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        sys_mode[`SPS_LN_TDO] && !swd_active |->
        pad_out[`SPS_LN_TDO] == scan_tdo_data
        && pad_oe_n[`SPS_LN_TDO] == !scan_tdo_en)
        else $error("trace reached data-out pin in scan-chain mode");

    chk_trace_swd: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        sys_mode[`SPS_LN_TDO] && swd_active |->
        pad_out[`SPS_LN_TDO] == async_trace_output
        && !pad_oe_n[`SPS_LN_TDO])
        else $error("trace not driven under serial-wire debug");

    chk_cfg_any_mode: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        reg_wr && cfg_hit |=> pad_cfg[$past(cfg_idx)] == $past(reg_wdata[7:0]))
        else $error("pad settings write not applied");

    chk_one_owner: assert property (@(posedge core_clk)
        disable iff (!rst_n_sync)
        !sys_mode[`SPS_LN_TDI] |-> pad_oe_n[`SPS_LN_TDI] ==
        !(cfg_reg[`SPS_LN_TDI].periph_own ? periph_drive[`SPS_LN_TDI]
                                          : port_ctl_drive[`SPS_LN_TDI]))
        else $error("data-in line driven by the wrong owner");

endmodule // sps_system_io_pin_select

/* sps_probe.sv */
// Debug probe model that drives the test clock and mode/data pads
`timescale 1ns/1ps
module sps_probe (
    input wire logic core_clk,
    output logic tck,
    output logic tms
);
    // Idle probe: clock parked low, mode line held high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
    end

    // One probe bit; each level is held 4 core cycles, as 3 are needed
    task automatic bit_out(input logic b);
        tms <= b;
        tck <= 1'b0;
        repeat (4) @(posedge core_clk);
        tck <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    // Line reset, 16-bit word LSB first, line reset; clock stops low after
    task automatic send(input logic [15:0] w, input int nres);
        for (int i = 0; i < nres; i++) bit_out(1'b1);
        for (int i = 0; i < 16; i++) bit_out(w[i]);
        for (int i = 0; i < nres; i++) bit_out(1'b1);
        tck <= 1'b0;
    endtask
endmodule // sps_probe

/* testbench.sv */
// Self-checking bench for the system I/O pin select block
`timescale 1ns/1ps
`include "sps_map.svh"
module testbench;
    import sps_pkg::*;
    localparam int NRES = 4;
    logic core_clk, reset_n, reg_wr, reg_rd, bsel, p_tck, p_tms;
    logic tdo_d, tdo_en, swd_o, swd_dr, trace, bscan, swd, erase;
    logic dtck, dtms, dtdi;
    sps_addr_t reg_addr;
    sps_data_t reg_wdata, reg_rdata;
    logic [4:0] ext, pad_out, pad_oe_n, pad_wire, far, pc_in, pe_in;
    logic [4:0] pc_out, pc_dr, pe_out, pe_dr;
    sps_pad_cfg_s [4:0] pad_cfg;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    // Pad wire: the block wins where it drives, else the board or probe
    assign far = {ext[4], p_tck, p_tms, ext[1:0]};
    assign pad_wire = (~pad_oe_n & pad_out) | (pad_oe_n & far);

    sps_system_io_pin_select #(.N_LINES(5), .LINE_RESET_BITS(NRES)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pad_in(pad_wire), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_cfg(pad_cfg),
        .boundary_scan_select_pin(bsel), .bscan_mode(bscan),
        .dbg_tck(dtck), .dbg_tms(dtms), .dbg_tdi(dtdi),
        .scan_tdo_data(tdo_d), .scan_tdo_en(tdo_en), .swdio_out(swd_o),
        .swdio_drive(swd_dr), .async_trace_output(trace),
        .swd_active(swd), .erase_request(erase), .port_ctl_out(pc_out),
        .port_ctl_drive(pc_dr), .port_ctl_in(pc_in), .periph_out(pe_out),
        .periph_drive(pe_dr), .periph_in(pe_in)
    );

    sps_probe i_probe (.core_clk(core_clk), .tck(p_tck), .tms(p_tms));

    // Free-running core clock, 5 ns period
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Hang guard: far above the roughly 1300 cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Write: one strobe cycle; effect shows after the following edge
    task automatic wr(input sps_addr_t a, input sps_data_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read: data stand only in the cycle after the strobe
    task automatic rd(input sps_addr_t a, input sps_data_t exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // Pads pass two sync flops, so three edges settle them
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic close_out();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        {reg_wr, reg_rd, bsel, tdo_d, tdo_en, swd_o, swd_dr, trace} = 8'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        {pc_out, pc_dr, pe_out, pe_dr, ext} = 25'h000_0000;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        settle(3);
        rd(`SPS_OFF_SYSIO, 32'h0000_0000);
        check(pad_oe_n[4:2], 3'b111);
        check(swd, 1'b0);
        // Each line keeps its own pad settings
        for (int i = 0; i < 5; i++)
            wr(`SPS_OFF_PADCFG + 8'(4 * i), 32'(8'h3C ^ 8'(i)));
        for (int i = 0; i < 5; i++) begin
            rd(`SPS_OFF_PADCFG + 8'(4 * i), 32'(8'h3C ^ 8'(i)));
            check(pad_cfg[i], 8'h3C ^ 8'(i));
        end
        wr(8'h08, 32'h0000_10F0);
        rd(8'h08, 32'h0000_0000);
        rd(`SPS_OFF_SYSIO, 32'h0000_0000);
        for (int i = 0; i < 5; i++)
            wr(`SPS_OFF_PADCFG + 8'(4 * i), 32'h0000_0000);
        // Erase line in system mode, then handed to the port controller and then the peripheral
        ext[4] <= 1'b1;
        settle(3);
        check(erase, 1'b1);
        rd(`SPS_OFF_STATUS, 32'h0000_0144);
        wr(`SPS_OFF_SYSIO, 32'h0000_1000);
        check(erase, 1'b0);
        ext[4] <= 1'b0;
        pc_dr[4] <= 1'b1;
        pe_out[4] <= 1'b1;
        pe_dr[4] <= 1'b0;
        settle(1);
        check({pad_oe_n[4], pad_out[4]}, 2'b00);
        wr(`SPS_OFF_PADCFG + 8'h10, 32'h0000_0080);
        check(pad_oe_n[4], 1'b1);
        pe_dr[4] <= 1'b1;
        settle(1);
        check({pad_oe_n[4], pad_out[4]}, 2'b01);
        // Peripheral sees its own line only once the pad has synchronised
        settle(2);
        check(pe_in[4], 1'b1);
        wr(`SPS_OFF_PADCFG + 8'h10, 32'h0000_0000);
        // Debug select bits 7..4 one at a time
        ext[1:0] <= 2'b11;
        pc_dr <= 5'h0F;
        pc_out <= 5'h0A;
        for (int b = 4; b < 8; b++) begin
            wr(`SPS_OFF_SYSIO, 32'h1 << b);
            settle(3);
            check(pad_oe_n, 5'(~(5'h01 << (b - 4))));
            check(pad_out[b - 4], pc_out[b - 4]);
            check(pc_in[b - 4], pc_out[b - 4]);
            check(pe_in, 5'h00);
            check({dtck, dtms, dtdi}, {1'b0, b != 6, b != 4});
        end
        wr(`SPS_OFF_SYSIO, 32'h0000_0000);
        pc_dr <= 5'h00;
        // Boundary-scan select pin
        bsel <= 1'b1;
        settle(3);
        check(bscan, 1'b1);
        bsel <= 1'b0;
        settle(3);
        check(bscan, 1'b0);
        // Data-out pin belongs to the scan TAP while in scan-chain mode
        tdo_en <= 1'b1;
        tdo_d <= 1'b1;
        settle(1);
        check({pad_oe_n[1], pad_out[1]}, 2'b01);
        // Return word is refused in scan-chain mode
        i_probe.send(`SPS_SEQ_TO_JTAG, NRES);
        settle(8);
        check(swd, 1'b0);
        // Switch word is ignored while the clock line is general I/O
        wr(`SPS_OFF_SYSIO, 32'h0000_0080);
        i_probe.send(`SPS_SEQ_TO_SWD, NRES);
        settle(8);
        check(swd, 1'b0);
        wr(`SPS_OFF_SYSIO, 32'h0000_0000);
        i_probe.send(`SPS_SEQ_TO_SWD, NRES);
        settle(8);
        check(swd, 1'b1);
        trace <= 1'b1;
        swd_dr <= 1'b1;
        settle(1);
        check({pad_oe_n[1], pad_out[1]}, 2'b01);
        check({pad_oe_n[2], pad_out[2]}, {1'b0, swd_o});
        swd_dr <= 1'b0;
        i_probe.send(16'h1234, NRES);
        settle(8);
        check(swd, 1'b1);
        i_probe.send(`SPS_SEQ_TO_JTAG, NRES);
        settle(8);
        check(swd, 1'b0);
        // Second reset in mid-run returns every pin to its system role
        i_probe.send(`SPS_SEQ_TO_SWD, NRES);
        wr(`SPS_OFF_SYSIO, 32'h0000_10F0);
        reset_n <= 1'b0;
        settle(2);
        check(swd, 1'b0);
        reset_n <= 1'b1;
        settle(3);
        rd(`SPS_OFF_SYSIO, 32'h0000_0000);
        close_out();
    end
endmodule // testbench
